// *** design/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // Register byte addresses on the APB window
  localparam logic [7:0] OFS_STATUS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_STATUS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
  localparam logic [7:0] OFS_COMPARE_HIGH = 8'h10;
  localparam logic [7:0] OFS_COMPARE_LOW = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;

  // Field positions, status and control one
  localparam int SC1_FLAG_BIT = 7;
  localparam int SC1_IRQ_EN_BIT = 6;
  localparam int SC1_CONT_BIT = 5;
  // Field positions, status and control two
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_CMP_EN_BIT = 5;
  localparam int SC2_CMP_GT_BIT = 4;
  // Field positions, configuration
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;

  // Reset values
  localparam logic [7:0] SC1_RESET = 8'h1F;
  localparam logic [7:0] SC2_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CV_RESET = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // Channel codes
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [4:0] CHAN_RSV = 5'h1C;

  // Rounding and saturation limits
  localparam logic [12:0] ROUND10_ADD = 13'h0002;
  localparam logic [9:0] ROUND8_ADD = 10'h001;
  localparam logic [11:0] MAX10 = 12'h3FF;
  localparam logic [11:0] MAX8 = 12'h0FF;

  typedef enum logic [1:0] {
    MODE_8 = 2'b00,
    MODE_12 = 2'b01,
    MODE_10 = 2'b10,
    MODE_RSV = 2'b11
  } res_mode_t;

  typedef enum logic [1:0] {
    CLK_BUS = 2'b00,
    CLK_BUS_HALF = 2'b01,
    CLK_ALT = 2'b10,
    CLK_ASYNC = 2'b11
  } clk_src_t;

  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } conv_state_t;

  // Controls toward the analog converter
  typedef struct packed {
    logic start;
    logic abort;
    logic enable;
    logic active;
    logic low_power;
    logic long_sample;
    logic conv_clk_en;
    res_mode_t mode;
  } conv_ctrl_t;

  // Raw answer from the analog converter
  typedef struct packed {
    logic valid;
    logic [11:0] raw;
  } conv_data_t;

  typedef struct packed {
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic [7:0] cvh;
    logic [7:0] cvl;
    logic [7:0] cfg;
    logic [11:0] result;
    logic lock;
    conv_state_t fsm;
    logic half_tog;
    logic [2:0] div_cnt;
    logic [2:0] alt_sync;
    logic [2:0] ack_sync;
    logic alt_level;
    logic ack_level;
    logic start_pulse;
    logic abort_pulse;
    logic clk_tick;
    logic [31:0] rdata;
  } state_t;

endpackage

// *** design/adc_result_compare_config.sv ***
// What this block does
// - Result high holds top four bits at 12-bit, top two at 10-bit.
// - Unused upper result bits read zero at 10-bit and 8-bit.
// - Results load on completion unless compare enabled and false.
// - Reading result high at 12/10-bit locks results until result low read.
// - Completions while locked are discarded.
// - At 8-bit, reading result high creates no lock.
// - Resolution change makes results invalid until next conversion.
// - Result low holds low eight bits, or all of an 8-bit result.
// - Compare high gives upper compare bits; ignored at 8-bit.
// - Compare low eight bits compared to low result bits in all modes.
// - Config bit 7 selects high speed or low power.
// - Config bit 4 selects short or long sample time.
// - Config bits 3:2 select 8, 12 or 10 bit; 11 reserved.
// - Config bits 6:5 divide input clock by 1, 2, 4 or 8.
// - Config bits 1:0 pick bus, half bus, alternate or async clock.
// - Reset selects the undivided bus clock.
// - Converter disabled in reset and when channel is all ones.
// - Between conversions the converter idles at lowest power.
// - Raw 12-bit or 9-bit result rounded to 10 or 8 bits.
// - Completion sets the flag; interrupt raised if enabled.
// - Compare enable turns on automatic compare in every mode.
// - Async clock keeps running in wait and stop3 when selected.
// - Flag clears on status one write or result low read.
// - Greater select: true if result >= value, else if result < value.
// - Config or compare writes abort a conversion; results untouched unless the resolution changes.
// - Channel all ones disables; 11100 is reserved.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps

module adc_result_compare_config (
  input wire logic pclk, // APB clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 = write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic alternate_clock_in, // Alternate clock, asynchronous
  input wire logic async_conv_clock, // Internal async clock, asynchronous
  input wire logic low_power_mode, // Device is in wait or stop3
  input wire adc_ctrl_pkg::conv_data_t conv_data, // Raw result from core
  output adc_ctrl_pkg::conv_ctrl_t conv_ctrl, // Controls to core
  output logic async_clock_run, // Keep async clock generator on
  output logic conv_irq // Completion interrupt
);
  import adc_ctrl_pkg::*;

  state_t s;
  state_t next_s;

  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  res_mode_t mode;
  clk_src_t clk_sel;
  logic [1:0] div_sel;
  logic [2:0] div_max;
  logic src_tick;
  logic alt_rise;
  logic ack_rise;
  logic abort_req;
  logic start_req;
  logic busy;
  logic cont;
  logic cmp_en;
  logic cmp_gt;
  logic [12:0] sum10;
  logic [9:0] sum8;
  logic [11:0] rounded;
  logic [11:0] cmp_val;
  logic cmp_true;
  logic blocked;
  logic [31:0] rmux;
  logic irq_en;
  logic [4:0] chan;
  logic low_pwr;
  logic long_smp;
  logic rd_high;
  logic rd_low;
  logic mode_chg;
  logic stays_busy;

  always_comb begin
    next_s = s;
    // Defaults keep every temporary driven even when a select is unknown
    mapped = 1'b0;
    rmux = 32'h00000000;
    src_tick = 1'b0;
    rounded = 12'h000;
    cmp_val = 12'h000;
    stays_busy = 1'b0;
    acc = psel & penable;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    mode = res_mode_t'(s.cfg[CFG_MODE_LSB +: 2]);
    if (mode == MODE_RSV) begin
      mode = MODE_8;
    end
    clk_sel = clk_src_t'(s.cfg[CFG_CLK_LSB +: 2]);
    div_sel = s.cfg[CFG_DIV_LSB +: 2];
    busy = (s.fsm == ST_BUSY);
    cont = s.sc1[SC1_CONT_BIT];
    cmp_en = s.sc2[SC2_CMP_EN_BIT];
    cmp_gt = s.sc2[SC2_CMP_GT_BIT];
    irq_en = s.sc1[SC1_IRQ_EN_BIT];
    chan = s.sc1[4:0];
    low_pwr = s.cfg[CFG_LOW_POWER_BIT];
    long_smp = s.cfg[CFG_LONG_SAMPLE_BIT];
    rd_high = rd & (paddr == OFS_RESULT_HIGH);
    rd_low = rd & (paddr == OFS_RESULT_LOW);
    mode_chg = wr & (paddr == OFS_CONFIG) &
               (pwdata[CFG_MODE_LSB +: 2] != s.cfg[CFG_MODE_LSB +: 2]);

    // Address decode and registered read data
    unique case (paddr)
      OFS_STATUS_CONTROL_ONE: begin
        mapped = 1'b1;
        rmux = {24'h000000, s.sc1};
      end
      OFS_STATUS_CONTROL_TWO: begin
        mapped = 1'b1;
        rmux = {24'h000000, busy, s.sc2[6:0]};
      end
      OFS_RESULT_HIGH: begin
        mapped = 1'b1;
        rmux = {28'h0000000, s.result[11:8]};
      end
      OFS_RESULT_LOW: begin
        mapped = 1'b1;
        rmux = {24'h000000, s.result[7:0]};
      end
      OFS_COMPARE_HIGH: begin
        mapped = 1'b1;
        rmux = {24'h000000, s.cvh};
      end
      OFS_COMPARE_LOW: begin
        mapped = 1'b1;
        rmux = {24'h000000, s.cvl};
      end
      OFS_CONFIG: begin
        mapped = 1'b1;
        rmux = {24'h000000, s.cfg};
      end
      default: begin
        mapped = 1'b0;
        rmux = 32'h00000000;
      end
    endcase
    // Captured in the setup cycle so prdata is a flop in the access phase
    if (psel & ~penable & ~pwrite) begin
      next_s.rdata = rmux;
    end

    // Pin clocks: three stages, a change counts once stages two and three agree
    next_s.alt_sync = {s.alt_sync[1:0], alternate_clock_in};
    next_s.ack_sync = {s.ack_sync[1:0], async_conv_clock};
    alt_rise = 1'b0;
    ack_rise = 1'b0;
    // Tracking the agreed level counts each rising pin edge exactly once
    if (s.alt_sync[1] == s.alt_sync[2]) begin
      next_s.alt_level = s.alt_sync[2];
      alt_rise = s.alt_sync[2] & ~s.alt_level;
    end
    if (s.ack_sync[1] == s.ack_sync[2]) begin
      next_s.ack_level = s.ack_sync[2];
      ack_rise = s.ack_sync[2] & ~s.ack_level;
    end

    // Input clock selection
    next_s.half_tog = ~s.half_tog;
    unique case (clk_sel)
      CLK_BUS: begin
        src_tick = 1'b1;
      end
      CLK_BUS_HALF: begin
        // Every second bus cycle
        src_tick = s.half_tog;
      end
      CLK_ALT: begin
        src_tick = alt_rise;
      end
      CLK_ASYNC: begin
        // Async source keeps ticking in wait and stop3
        src_tick = ack_rise;
      end
    endcase

    // Conversion clock divider, cleared and held at zero while idle to save power
    div_max = 3'((4'h1 << div_sel) - 4'h1);
    next_s.clk_tick = 1'b0;
    if (!busy) begin
      next_s.div_cnt = 3'h0;
    end else if (src_tick) begin
      if (s.div_cnt >= div_max) begin
        next_s.div_cnt = 3'h0;
        next_s.clk_tick = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 3'h1;
      end
    end

    // Rounding of the raw answer
    sum10 = {1'b0, conv_data.raw} + ROUND10_ADD;
    sum8 = {1'b0, conv_data.raw[8:0]} + ROUND8_ADD;
    unique case (mode)
      MODE_12: begin
        rounded = conv_data.raw;
      end
      MODE_10: begin
        // Half an output step added, then saturated at full scale
        rounded = sum10[12] ? MAX10 : {2'b00, sum10[11:2]};
      end
      default: begin
        rounded = sum8[9] ? MAX8 : {4'h0, sum8[8:1]};
      end
    endcase

    // Compare value assembly
    unique case (mode)
      MODE_12: begin
        cmp_val = {s.cvh[3:0], s.cvl};
      end
      MODE_10: begin
        cmp_val = {2'b00, s.cvh[1:0], s.cvl};
      end
      default: begin
        // High compare byte plays no part at eight bits
        cmp_val = {4'h0, s.cvl};
      end
    endcase
    cmp_true = cmp_gt ? (rounded >= cmp_val) : (rounded < cmp_val);
    blocked = s.lock & (mode != MODE_8);

    // Register writes
    start_req = 1'b0;
    abort_req = 1'b0;
    next_s.start_pulse = 1'b0;
    next_s.abort_pulse = 1'b0;
    if (wr) begin
      unique case (paddr)
        OFS_STATUS_CONTROL_ONE: begin
          next_s.sc1 = {1'b0, pwdata[6:0]};
          abort_req = 1'b1;
          start_req = (pwdata[4:0] != CHAN_OFF) &
                      (pwdata[4:0] != CHAN_RSV);
        end
        OFS_STATUS_CONTROL_TWO: begin
          // Bits 3:0 are not implemented and read as zero
          next_s.sc2 = {1'b0, pwdata[6:4], 4'h0};
          abort_req = 1'b1;
        end
        OFS_COMPARE_HIGH: begin
          next_s.cvh = pwdata[7:0];
          abort_req = 1'b1;
        end
        OFS_COMPARE_LOW: begin
          next_s.cvl = pwdata[7:0];
          abort_req = 1'b1;
        end
        OFS_CONFIG: begin
          next_s.cfg = pwdata[7:0];
          abort_req = 1'b1;
          if (mode_chg) begin
            // Old data no longer matches the new layout
            next_s.result = RESULT_RESET;
            next_s.lock = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Read side effects
    // High then low is read as a pair; the lock keeps the pair coherent
    if (rd_high && mode != MODE_8) begin
      next_s.lock = 1'b1;
    end
    if (rd_low) begin
      next_s.lock = 1'b0;
      next_s.sc1[SC1_FLAG_BIT] = 1'b0;
    end

    // Conversion sequencing
    if (abort_req) begin
      // Abort leaves results alone; only a resolution change above clears them
      next_s.fsm = ST_IDLE;
      next_s.abort_pulse = busy;
      if (start_req) begin
        next_s.fsm = ST_BUSY;
        next_s.start_pulse = 1'b1;
      end
    end else if (busy && conv_data.valid) begin
      if (blocked) begin
        // Result lost; a compare miss ends the run only outside continuous mode
        if (!cmp_en || cmp_true || cont) begin
          next_s.start_pulse = 1'b1;
        end else begin
          next_s.fsm = ST_IDLE;
        end
      end else begin
        if (!cmp_en || cmp_true) begin
          next_s.result = rounded;
          next_s.sc1[SC1_FLAG_BIT] = 1'b1;
        end
        // Continuous mode chains the next conversion at once
        if (cont) begin
          next_s.start_pulse = 1'b1;
        end else begin
          next_s.fsm = ST_IDLE;
        end
      end
    end

    // No divided tick may outlive the conversion it belongs to
    stays_busy = (next_s.fsm == ST_BUSY);
    if (!stays_busy) begin
      next_s.clk_tick = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.sc1 <= SC1_RESET;
      s.sc2 <= SC2_RESET;
      s.cvh <= CV_RESET;
      s.cvl <= CV_RESET;
      s.cfg <= CFG_RESET;
      s.result <= RESULT_RESET;
      s.lock <= 1'b0;
      s.fsm <= ST_IDLE;
      s.half_tog <= 1'b0;
      s.div_cnt <= 3'h0;
      s.alt_sync <= 3'h0;
      s.ack_sync <= 3'h0;
      s.alt_level <= 1'b0;
      s.ack_level <= 1'b0;
      s.start_pulse <= 1'b0;
      s.abort_pulse <= 1'b0;
      s.clk_tick <= 1'b0;
      s.rdata <= 32'h00000000;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    conv_ctrl.start = s.start_pulse;
    conv_ctrl.abort = s.abort_pulse;
    conv_ctrl.enable = (chan != CHAN_OFF);
    conv_ctrl.active = busy;
    conv_ctrl.low_power = low_pwr;
    conv_ctrl.long_sample = long_smp;
    conv_ctrl.conv_clk_en = s.clk_tick;
    conv_ctrl.mode = mode;
  end

  // The generator stays on in wait and stop3 so conversions can run there
  assign async_clock_run = (clk_sel == CLK_ASYNC) & conv_ctrl.enable &
                           (busy | low_power_mode);
  assign conv_irq = s.sc1[SC1_FLAG_BIT] & irq_en;

endmodule // adc_result_compare_config

// *** test/adc_result_compare_config_props.sv ***
`timescale 1ns/100ps
module adc_result_compare_config_props
  import adc_ctrl_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic alternate_clock_in, // alt clock
  input wire logic async_conv_clock, // async clock
  input wire logic low_power_mode, // wait or stop3
  input wire adc_ctrl_pkg::conv_data_t conv_data, // from core
  input wire adc_ctrl_pkg::conv_ctrl_t conv_ctrl, // to core
  input wire logic async_clock_run, // async clock on
  input wire logic conv_irq // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr;
    psel && penable && pwrite;
  endsequence
  sequence s_rl_rd;
    psel && penable && !pwrite && paddr == OFS_RESULT_LOW && !conv_data.valid;
  endsequence
  property p_start_en;
    conv_ctrl.start |-> conv_ctrl.enable;
  endproperty
  a_start_en: assert property (p_start_en)
    else $error("start while disabled");
  property p_start_act;
    conv_ctrl.start |-> conv_ctrl.active;
  endproperty
  a_start_act: assert property (p_start_act)
    else $error("start without active");
  property p_clk_en;
    conv_ctrl.conv_clk_en |-> conv_ctrl.active;
  endproperty
  a_clk_en: assert property (p_clk_en)
    else $error("conversion clock while idle");
  property p_mode;
    conv_ctrl.mode != MODE_RSV;
  endproperty
  a_mode: assert property (p_mode)
    else $error("reserved mode passed on");
  property p_async;
    async_clock_run |-> conv_ctrl.enable;
  endproperty
  a_async: assert property (p_async)
    else $error("async clock on while disabled");
  property p_abort;
    conv_ctrl.abort |-> $past(psel && penable && pwrite);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort without a write");
  property p_no_start;
    s_wr ##0 (paddr != OFS_STATUS_CONTROL_ONE && !conv_data.valid)
      |=> !conv_ctrl.start;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("start after a non-start write");
  property p_irq;
    $rose(conv_irq) |-> $past(conv_data.valid) || $past(pwrite && penable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without completion");
  property p_flag_clr;
    s_rl_rd |=> !conv_irq;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag kept after low read");
endmodule // adc_result_compare_config_props

bind adc_result_compare_config adc_result_compare_config_props u_props (.*);

// *** test/adc_result_compare_config_tb_top.sv ***
`timescale 1ns/100ps
module adc_result_compare_config_tb_top;
  import adc_ctrl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, perr, alt = 0, ack = 0, lpm = 0;
  logic async_clock_run, conv_irq;
  conv_data_t conv_data = '0;
  conv_ctrl_t conv_ctrl;
  int bad_count = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  logic [3:0] pin_div = 4'h0;
  // Slow pin clocks with periods of 8 and 16 bus cycles
  always @(posedge pclk) begin
    pin_div <= pin_div + 4'h1;
    alt <= pin_div[2];
    ack <= pin_div[3];
  end
  adc_result_compare_config dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .alternate_clock_in(alt),
    .async_conv_clock(ack),
    .low_power_mode(lpm),
    .conv_data(conv_data),
    .conv_ctrl(conv_ctrl),
    .async_clock_run(async_clock_run),
    .conv_irq(conv_irq)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(q, e);
  endtask
  // Core answers one cycle after start, never while idle
  task automatic conv(input logic [11:0] raw);
    apb(1, OFS_STATUS_CONTROL_ONE, 32'h40);
    for (int i = 0; i < 20 && conv_ctrl.start !== 1'b1; i++) @(posedge pclk);
    chk(conv_ctrl.start, 1);
    conv_data <= {1'b1, raw};
    @(posedge pclk);
    conv_data.valid <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_reset;
    chk(conv_ctrl.enable, 0);
    rd(OFS_CONFIG, 32'h0);
    rd(OFS_STATUS_CONTROL_ONE, 32'h1F);
    rd(8'h1C, 32'h0);
    chk(perr, 1);
    apb(1, OFS_STATUS_CONTROL_ONE, 32'h1C);
    @(posedge pclk);
    chk(conv_ctrl.start, 0);
    chk(conv_ctrl.active, 0);
    chk(conv_ctrl.enable, 1);
  endtask
  task automatic t_modes;
    logic [35:0] tb[6] = '{36'h04ABC0ABC, 36'h08FFF03FF, 36'h0800600_02,
      36'h001FF00FF, 36'h00003_0002, 36'h0C004_0002};
    foreach (tb[i]) begin
      apb(1, OFS_CONFIG, tb[i][35:28]);
      conv(tb[i][27:16]);
      chk(conv_irq, 1);
      chk(conv_ctrl.mode, tb[i][31:30] == 2'b11 ? 2'b00 : tb[i][31:30]);
      rd(OFS_RESULT_HIGH, tb[i][15:8]);
      rd(OFS_RESULT_LOW, tb[i][7:0]);
      @(posedge pclk);
      chk(conv_irq, 0);
    end
    apb(1, OFS_CONFIG, 32'h0);
    rd(OFS_RESULT_HIGH, 32'h0);
    conv(12'h010);
    rd(OFS_RESULT_LOW, 32'h08);
    apb(1, OFS_CONFIG, 32'h04);
    rd(OFS_RESULT_LOW, 32'h0);
    conv(12'h123);
    rd(OFS_RESULT_HIGH, 32'h01);
    conv(12'h456);
    chk(conv_irq, 0);
    rd(OFS_RESULT_LOW, 32'h23);
  endtask
  task automatic t_clk;
    logic [7:0] cf[7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03};
    int ex[7] = '{64, 32, 16, 8, 32, 8, 4};
    int n;
    apb(1, OFS_CONFIG, 32'h90);
    @(posedge pclk);
    chk(conv_ctrl.low_power, 1);
    chk(conv_ctrl.long_sample, 1);
    foreach (cf[i]) begin
      apb(1, OFS_CONFIG, cf[i]);
      apb(1, OFS_STATUS_CONTROL_ONE, 32'h0);
      // Let the three-flop synchronisers fill before counting
      repeat (8) @(posedge pclk);
      n = 0;
      repeat (64) begin
        @(posedge pclk);
        n += conv_ctrl.conv_clk_en === 1'b1;
      end
      chk(n, ex[i]);
      chk(conv_ctrl.active, 1);
    end
    apb(1, OFS_STATUS_CONTROL_TWO, 32'h0);
    @(posedge pclk);
    chk(conv_ctrl.abort, 1);
    chk(conv_ctrl.active, 0);
    lpm <= 1;
    repeat (2) @(posedge pclk);
    chk(async_clock_run, 1);
    lpm <= 0;
    repeat (2) @(posedge pclk);
    chk(async_clock_run, 0);
  endtask
  task automatic t_cmp;
    logic [27:0] tb[4] = '{28'h3010080, 28'h3008080, 28'h200FE7F,
      28'h201007F};
    apb(1, OFS_CONFIG, 32'h0);
    apb(1, OFS_COMPARE_HIGH, 32'hFF);
    apb(1, OFS_COMPARE_LOW, 32'h80);
    foreach (tb[i]) begin
      apb(1, OFS_STATUS_CONTROL_TWO, tb[i][27:20]);
      conv(tb[i][19:8]);
      rd(OFS_RESULT_LOW, tb[i][7:0]);
    end
    // 12-bit: compare high byte counts, so 0xA55 misses 0xF80
    apb(1, OFS_CONFIG, 32'h04);
    apb(1, OFS_STATUS_CONTROL_TWO, 32'h30);
    conv(12'hA55);
    rd(OFS_RESULT_LOW, 32'h00);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_modes();
    t_clk();
    t_cmp();
    print_verdict();
  end
  initial begin
    #2000000;
    bad_count++;
    print_verdict();
  end
endmodule // adc_result_compare_config_tb_top
